// ==== hw/mbsrh_defines.svh ====
// offsets, field positions, reset values and limits of the slave request handler
`ifndef MBSRH_DEFINES_SVH
`define MBSRH_DEFINES_SVH
// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define MBSRH_REG_CTRL 8'h00
`define MBSRH_REG_ADDR 8'h04
`define MBSRH_REG_UNIT 8'h08
`define MBSRH_REG_STAT 8'h0c
`define MBSRH_REG_NREQ 8'h10
`define MBSRH_REG_NEXC 8'h14
// ----------------------------------------------------------------
// control fields and reset values
// ----------------------------------------------------------------
`define MBSRH_CTRL_SER 0
`define MBSRH_CTRL_TCP 1
`define MBSRH_CTRL_SIX 2
`define MBSRH_CTRL_RESTART 3
`define MBSRH_CTRL_RST_VAL 3'h0
`define MBSRH_ADDR_RST_VAL 8'h01
`define MBSRH_UNIT_RST_VAL 8'hff
// ----------------------------------------------------------------
// function codes, exception codes, limits
// ----------------------------------------------------------------
`define MBSRH_FC_RCOIL 8'h01
`define MBSRH_FC_RDIN 8'h02
`define MBSRH_FC_RHOLD 8'h03
`define MBSRH_FC_RINREG 8'h04
`define MBSRH_FC_WCOIL 8'h05
`define MBSRH_FC_WREG 8'h06
`define MBSRH_FC_EXCST 8'h07
`define MBSRH_FC_DIAG 8'h08
`define MBSRH_FC_WCOILS 8'h0f
`define MBSRH_FC_WREGS 8'h10
`define MBSRH_EXC_FLAG 8'h80
`define MBSRH_EXC_ILL_FUNC 8'h01
`define MBSRH_EXC_ILL_VAL 8'h03
`define MBSRH_LIM_5DIG 17'h0270f
`define MBSRH_LIM_6DIG 17'h0ffff
`define MBSRH_SCRATCH_BASE 17'h0c350
`define MBSRH_SCRATCH_CNT 16'h0008
`define MBSRH_MAX_SESS 3'h5
`define MBSRH_QMAX_RBIT 16'h07d0
`define MBSRH_QMAX_RREG 16'h007d
`define MBSRH_QMAX_WBIT 16'h07b0
`define MBSRH_QMAX_WREG 16'h007b
`define MBSRH_COIL_ON 16'hff00
`define MBSRH_COIL_OFF 16'h0000
`define MBSRH_DIAG_SUB 16'h0000
`define MBSRH_DIAG_LEN 8'h02
`endif

// ==== hw/mbsrh_pkg.sv ====
// types shared by the slave request handler
package mbsrh_pkg;
  typedef enum logic [1:0] {KIND_NONE, KIND_PHYS_IN, KIND_PHYS_OUT, KIND_DERIVED} mbsrh_kind_e;
  typedef enum logic [3:0] {S_IDLE, S_DISP, S_QRY, S_QWAIT, S_FETCH, S_FWAIT, S_WRITE,
                            S_EMIT, S_END, S_HDR, S_HDR2, S_EXC, S_SEND} mbsrh_state_e;
endpackage

// ==== hw/mbsrh_buf_if.sv ====
// response buffer carrier between request engine and transmitter
`timescale 1ns/1ps
`default_nettype none
interface mbsrh_buf_if;
  logic wr;
  logic [7:0] widx;
  logic [7:0] wbyte;
  logic send;
  logic [7:0] len;
  logic busy;
  modport eng (output wr, widx, wbyte, send, len, input busy);
  modport tx (input wr, widx, wbyte, send, len, output busy);
endinterface
`default_nettype wire

// ==== hw/mbsrh_txbuf.sv ====
// response byte buffer and byte-stream transmitter
`timescale 1ns/1ps
`default_nettype none
module mbsrh_txbuf #(
  parameter int DEPTH = 256
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  mbsrh_buf_if.tx bus,
  output logic rsp_valid,
  output logic [7:0] rsp_byte,
  output logic rsp_last,
  input wire logic rsp_ready
);
  logic [7:0] mem [DEPTH];
  logic [7:0] idx;
  logic [7:0] len;
  logic busy;
  logic take;

  assign take = busy && rsp_ready;
  assign bus.busy = busy;
  assign rsp_valid = busy;
  assign rsp_last = busy && (idx == len - 8'h01);

  always_ff @(posedge clk) begin
    if (ce && bus.wr) begin
      mem[bus.widx] <= bus.wbyte;
    end
  end

  // ----------------------------------------------------------------
  // transmit sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      idx <= 8'h00;
      len <= 8'h00;
      rsp_byte <= 8'h00;
    end else if (ce) begin
      if (bus.send) begin
        busy <= 1'b1;
        idx <= 8'h00;
        len <= bus.len;
        rsp_byte <= mem[0];
      end else if (take) begin
        if (rsp_last) begin
          busy <= 1'b0;
        end
        idx <= idx + 8'h01;
        rsp_byte <= mem[idx + 8'h01];
      end
    end
  end
endmodule // mbsrh_txbuf
`default_nettype wire

// ==== hw/mbsrh_top.sv ====
// slave/server request decoder and responder over the point database
//
// Behaviour
// - accept codes 1-7, 15, 16 on both paths
// - code 7 packs points 50000-50007, LSB first
// - diagnostic over TCP answers exception 1
// - diagnostic sub-function other than 0: exception 3
// - sub 0 size 2 echoes; else silence
// - point number is reference plus one
// - five-digit mode: points 1 to 9999
// - six-digit mode: points 1 to 65535
// - input types hit input/derived, output types output/derived
// - analog runs: width decides following registers
// - point format follows its configured object type
// - no existing point in bit read: exception 1
// - coil reads return output or derived points
// - input reads return input or derived points
// - missing points read zero when some exist
// - active only if enabled, latched at restart
// - one slave address for every serial port
// - five TCP sessions share one unit identifier
// - coil writes need output or derived point, else exception 1
// - register writes stop at first missing point
`include "mbsrh_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module mbsrh_top #(
  parameter int BUF_DEPTH = 256
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_tcp,
  input wire logic [2:0] req_sess,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_fc,
  input wire logic [15:0] req_ref,
  input wire logic [15:0] req_qty,
  input wire logic [15:0] req_sub,
  input wire logic [7:0] req_len,
  output logic pl_rd,
  output logic [7:0] pl_idx,
  input wire logic [7:0] pl_byte,
  output logic db_rd,
  output logic db_ana,
  output logic [16:0] db_num,
  input wire mbsrh_pkg::mbsrh_kind_e db_kind,
  input wire logic db_wide,
  input wire logic [31:0] db_val,
  output logic db_wr,
  output logic [31:0] db_wval,
  output logic rsp_valid,
  output logic [7:0] rsp_byte,
  output logic rsp_last,
  input wire logic rsp_ready,
  output logic rsp_tcp,
  output logic [2:0] rsp_sess
);
  import mbsrh_pkg::*;

  mbsrh_buf_if b ();
  mbsrh_state_e state, ret;
  logic [2:0] ctrl;
  logic ser_act, tcp_act;
  logic [7:0] slave_addr, unit_id, fc, exc_code, ridx, nemit, nfetch, pidx, bbyte;
  logic [15:0] ref0, qty, sub, cnt, nreq, nexc;
  logic [16:0] ptr, start, lim, boff;
  logic [31:0] acc;
  logic [2:0] bitpos;
  logic [7:0] len8;
  logic any, wide2;
  logic accept, in_rng, ok, rd_bin, rd_ana, wr_op, want_out;
  logic [7:0] byte_n;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `MBSRH_CTRL_RST_VAL;
      slave_addr <= `MBSRH_ADDR_RST_VAL;
      unit_id <= `MBSRH_UNIT_RST_VAL;
    end else if (ce && reg_wr) begin
      if (reg_addr == `MBSRH_REG_CTRL) begin
        ctrl <= reg_wdata[2:0];
      end else if (reg_addr == `MBSRH_REG_ADDR) begin
        slave_addr <= reg_wdata[7:0];
      end else if (reg_addr == `MBSRH_REG_UNIT) begin
        unit_id <= reg_wdata[7:0];
      end
    end
  end

  // enables reach the engine only through a restart strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_act <= 1'b0;
      tcp_act <= 1'b0;
    end else if (ce && reg_wr && reg_addr == `MBSRH_REG_CTRL && reg_wdata[`MBSRH_CTRL_RESTART]) begin
      ser_act <= reg_wdata[`MBSRH_CTRL_SER];
      tcp_act <= reg_wdata[`MBSRH_CTRL_TCP];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0000_0000;
    end else if (ce) begin
      if (!reg_rd) begin
        reg_rdata <= 32'h0000_0000;
      end else if (reg_addr == `MBSRH_REG_CTRL) begin
        reg_rdata <= {29'h0, ctrl};
      end else if (reg_addr == `MBSRH_REG_ADDR) begin
        reg_rdata <= {24'h0, slave_addr};
      end else if (reg_addr == `MBSRH_REG_UNIT) begin
        reg_rdata <= {24'h0, unit_id};
      end else if (reg_addr == `MBSRH_REG_STAT) begin
        reg_rdata <= {29'h0, state != S_IDLE, tcp_act, ser_act};
      end else if (reg_addr == `MBSRH_REG_NREQ) begin
        reg_rdata <= {16'h0, nreq};
      end else if (reg_addr == `MBSRH_REG_NEXC) begin
        reg_rdata <= {16'h0, nexc};
      end else begin
        reg_rdata <= 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nreq <= 16'h0000;
      nexc <= 16'h0000;
    end else if (ce) begin
      if (state == S_SEND) begin
        nreq <= nreq + 16'h0001;
      end
      if (state == S_EXC) begin
        nexc <= nexc + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  assign accept = req_tcp ? (tcp_act && req_addr == unit_id && req_sess < `MBSRH_MAX_SESS)
                          : (ser_act && req_addr == slave_addr);
  assign req_ready = (state == S_IDLE) && !b.busy;
  assign lim = ctrl[`MBSRH_CTRL_SIX] ? `MBSRH_LIM_6DIG : `MBSRH_LIM_5DIG;
  // scratchpad sits above the five-digit window, so status reads skip the range test
  assign in_rng = fc == `MBSRH_FC_EXCST || (ptr != 17'h0 && ptr <= lim);
  assign rd_bin = fc == `MBSRH_FC_RCOIL || fc == `MBSRH_FC_RDIN || fc == `MBSRH_FC_EXCST;
  assign rd_ana = fc == `MBSRH_FC_RHOLD || fc == `MBSRH_FC_RINREG;
  assign wr_op = fc == `MBSRH_FC_WCOIL || fc == `MBSRH_FC_WREG || fc == `MBSRH_FC_WCOILS
                 || fc == `MBSRH_FC_WREGS;
  assign want_out = fc != `MBSRH_FC_RDIN && fc != `MBSRH_FC_RINREG;
  // scratchpad points are accepted whatever their class
  assign ok = in_rng && db_kind != KIND_NONE && (fc == `MBSRH_FC_EXCST || db_kind == KIND_DERIVED
              || db_kind == (want_out ? KIND_PHYS_OUT : KIND_PHYS_IN));
  assign byte_n = bbyte | ({7'h0, ok & db_val[0]} << bitpos);
  assign boff = ptr - start;
  assign db_rd = (state == S_QRY) && in_rng;
  assign db_ana = rd_ana || fc == `MBSRH_FC_WREG || fc == `MBSRH_FC_WREGS;
  assign db_num = ptr;
  assign db_wr = state == S_WRITE;
  assign pl_rd = state == S_FETCH;
  assign pl_idx = pidx;
  assign b.wr = state == S_EMIT || state == S_HDR || state == S_HDR2 || state == S_EXC;
  assign b.widx = (state == S_EMIT) ? ridx : (state == S_HDR2 ? 8'h01 : 8'h00);
  assign b.wbyte = state == S_EMIT ? acc[31:24] : (state == S_HDR2 ? len8 - 8'h02
                   : (state == S_EXC ? (fc | `MBSRH_EXC_FLAG) : fc));
  assign len8 = ridx;
  assign b.send = state == S_SEND;
  assign b.len = ridx;

  always_comb begin
    db_wval = 32'h0;
    if (fc == `MBSRH_FC_WCOIL) begin
      db_wval = {31'h0, qty == `MBSRH_COIL_ON};
    end else if (fc == `MBSRH_FC_WREG) begin
      db_wval = {16'h0, qty};
    end else if (fc == `MBSRH_FC_WCOILS) begin
      db_wval = {31'h0, acc[boff[2:0]]};
    end else if (fc == `MBSRH_FC_WREGS) begin
      db_wval = wide2 ? acc : {16'h0, acc[15:0]};
    end
  end

  // ----------------------------------------------------------------
  // request engine
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      ret <= S_IDLE;
      fc <= 8'h00;
      exc_code <= 8'h00;
      ref0 <= 16'h0;
      qty <= 16'h0;
      sub <= 16'h0;
      ptr <= 17'h0;
      start <= 17'h0;
      cnt <= 16'h0;
      ridx <= 8'h00;
      nemit <= 8'h00;
      nfetch <= 8'h00;
      pidx <= 8'h00;
      bbyte <= 8'h00;
      bitpos <= 3'h0;
      acc <= 32'h0;
      any <= 1'b0;
      wide2 <= 1'b0;
      rsp_tcp <= 1'b0;
      rsp_sess <= 3'h0;
    end else if (ce) begin
      case (state)
        S_IDLE: begin
          if (req_valid && req_ready) begin
            fc <= req_fc;
            ref0 <= req_ref;
            qty <= req_qty;
            sub <= req_sub;
            nfetch <= req_len;
            rsp_tcp <= req_tcp;
            rsp_sess <= req_sess;
            ptr <= {1'b0, req_ref} + 17'h1;
            start <= {1'b0, req_ref} + 17'h1;
            ridx <= 8'h02;
            bitpos <= 3'h0;
            bbyte <= 8'h00;
            any <= 1'b0;
            pidx <= 8'h00;
            state <= accept ? S_DISP : S_IDLE;
          end
        end
        S_DISP: begin
          cnt <= qty;
          state <= S_QRY;
          exc_code <= `MBSRH_EXC_ILL_VAL;
          if (fc == `MBSRH_FC_RCOIL || fc == `MBSRH_FC_RDIN) begin
            if (qty == 16'h0 || qty > `MBSRH_QMAX_RBIT) state <= S_EXC;
          end else if (rd_ana) begin
            if (qty == 16'h0 || qty > `MBSRH_QMAX_RREG) state <= S_EXC;
          end else if (fc == `MBSRH_FC_WCOILS) begin
            if (qty == 16'h0 || qty > `MBSRH_QMAX_WBIT) state <= S_EXC;
          end else if (fc == `MBSRH_FC_WREGS) begin
            if (qty == 16'h0 || qty > `MBSRH_QMAX_WREG) state <= S_EXC;
          end else if (fc == `MBSRH_FC_WCOIL) begin
            cnt <= 16'h1;
            if (qty != `MBSRH_COIL_ON && qty != `MBSRH_COIL_OFF) state <= S_EXC;
          end else if (fc == `MBSRH_FC_WREG) begin
            cnt <= 16'h1;
          end else if (fc == `MBSRH_FC_EXCST) begin
            ptr <= `MBSRH_SCRATCH_BASE;
            cnt <= `MBSRH_SCRATCH_CNT;
            ridx <= 8'h01;
          end else if (fc == `MBSRH_FC_DIAG) begin
            if (rsp_tcp) begin
              exc_code <= `MBSRH_EXC_ILL_FUNC;
              state <= S_EXC;
            end else if (sub != `MBSRH_DIAG_SUB) begin
              state <= S_EXC;
            end else if (nfetch != `MBSRH_DIAG_LEN) begin
              state <= S_IDLE;
            end else begin
              acc <= {sub, qty};
              nemit <= 8'h04;
              ridx <= 8'h01;
              ret <= S_HDR;
              state <= S_EMIT;
            end
          end else begin
            exc_code <= `MBSRH_EXC_ILL_FUNC;
            state <= S_EXC;
          end
        end
        S_QRY: state <= S_QWAIT;
        S_QWAIT: begin
          if (wr_op) begin
            wide2 <= db_wide && cnt >= 16'h2;
            if (!ok) begin
              exc_code <= `MBSRH_EXC_ILL_FUNC;
              state <= S_EXC;
            end else if (fc == `MBSRH_FC_WCOILS) begin
              pidx <= boff[10:3];
              nfetch <= 8'h01;
              state <= S_FETCH;
            end else if (fc == `MBSRH_FC_WREGS) begin
              nfetch <= (db_wide && cnt >= 16'h2) ? 8'h04 : 8'h02;
              state <= S_FETCH;
            end else begin
              state <= S_WRITE;
            end
          end else if (rd_bin) begin
            any <= any | ok;
            ptr <= ptr + 17'h1;
            cnt <= cnt - 16'h1;
            bitpos <= bitpos + 3'h1;
            if (bitpos == 3'h7 || cnt == 16'h1) begin
              acc <= {byte_n, 24'h0};
              bbyte <= 8'h00;
              nemit <= 8'h01;
              ret <= (cnt == 16'h1) ? S_END : S_QRY;
              state <= S_EMIT;
            end else begin
              bbyte <= byte_n;
              state <= S_QRY;
            end
          end else begin
            any <= any | ok;
            ptr <= ptr + 17'h1;
            state <= S_EMIT;
            nemit <= 8'h02;
            if (ok && db_wide) begin
              acc <= db_val;
              nemit <= (cnt >= 16'h2) ? 8'h04 : 8'h02;
              cnt <= (cnt >= 16'h2) ? cnt - 16'h2 : 16'h0;
              ret <= (cnt <= 16'h2) ? S_END : S_QRY;
            end else begin
              acc <= ok ? {db_val[15:0], 16'h0} : 32'h0;
              cnt <= cnt - 16'h1;
              ret <= (cnt == 16'h1) ? S_END : S_QRY;
            end
          end
        end
        S_FETCH: state <= S_FWAIT;
        S_FWAIT: begin
          acc <= {acc[23:0], pl_byte};
          pidx <= pidx + 8'h01;
          nfetch <= nfetch - 8'h01;
          state <= (nfetch == 8'h01) ? S_WRITE : S_FETCH;
        end
        S_WRITE: begin
          ptr <= ptr + 17'h1;
          if (cnt <= {15'h0, wide2} + 16'h1) begin
            acc <= {ref0, qty};
            nemit <= 8'h04;
            ridx <= 8'h01;
            ret <= S_HDR;
            state <= S_EMIT;
          end else begin
            cnt <= cnt - {15'h0, wide2} - 16'h1;
            state <= S_QRY;
          end
        end
        S_EMIT: begin
          acc <= {acc[23:0], 8'h00};
          ridx <= ridx + 8'h01;
          nemit <= nemit - 8'h01;
          if (nemit == 8'h01) state <= ret;
        end
        S_END: begin
          if (fc != `MBSRH_FC_EXCST && !any) begin
            exc_code <= `MBSRH_EXC_ILL_FUNC;
            state <= S_EXC;
          end else begin
            state <= S_HDR;
          end
        end
        S_HDR: state <= (rd_bin && fc != `MBSRH_FC_EXCST) || rd_ana ? S_HDR2 : S_SEND;
        S_HDR2: state <= S_SEND;
        S_EXC: begin
          acc <= {exc_code, 24'h0};
          ridx <= 8'h01;
          nemit <= 8'h01;
          ret <= S_SEND;
          state <= S_EMIT;
        end
        S_SEND: state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  mbsrh_txbuf #(.DEPTH(BUF_DEPTH)) u_tx (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .bus(b),
    .rsp_valid(rsp_valid),
    .rsp_byte(rsp_byte),
    .rsp_last(rsp_last),
    .rsp_ready(rsp_ready)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence s_exc_out;
    state == S_EXC ##1 state == S_EMIT ##1 state == S_SEND;
  endsequence
  property p_unsup;
    @(posedge clk iff ce) disable iff (!rst_n)
      state == S_DISP && fc > `MBSRH_FC_WREGS |=> s_exc_out ##0 $past(exc_code, 2) == 8'h01;
  endproperty
  a_unsup: assert property (p_unsup) else $error("unsupported code not refused");
  property p_scratch;
    @(posedge clk iff ce) disable iff (!rst_n)
      state == S_DISP && fc == `MBSRH_FC_EXCST |=> ptr == 17'h0c350 && cnt == 16'h0008;
  endproperty
  a_scratch: assert property (p_scratch) else $error("status read not at scratchpad");
  property p_diag_tcp;
    @(posedge clk iff ce) disable iff (!rst_n)
      state == S_DISP && fc == `MBSRH_FC_DIAG && rsp_tcp |=> exc_code == 8'h01 ##0 s_exc_out;
  endproperty
  a_diag_tcp: assert property (p_diag_tcp) else $error("diagnostic over tcp not refused");
  property p_diag_sub;
    @(posedge clk iff ce) disable iff (!rst_n)
      state == S_DISP && fc == `MBSRH_FC_DIAG && !rsp_tcp && sub != 16'h0
      |=> exc_code == 8'h03 && state == S_EXC;
  endproperty
  a_diag_sub: assert property (p_diag_sub) else $error("bad sub-function not refused");
  property p_diag_len;
    @(posedge clk iff ce) disable iff (!rst_n)
      state == S_DISP && fc == `MBSRH_FC_DIAG && !rsp_tcp && sub == 16'h0 && nfetch != 8'h02
      |=> state == S_IDLE ##1 !b.send;
  endproperty
  a_diag_len: assert property (p_diag_len) else $error("odd diagnostic size answered");
  property p_map;
    @(posedge clk iff ce) disable iff (!rst_n)
      state == S_IDLE && req_valid && req_ready |=> start == {1'b0, $past(req_ref)} + 17'h1;
  endproperty
  a_map: assert property (p_map) else $error("point number not reference plus one");
  property p_range;
    @(posedge clk iff ce) disable iff (!rst_n)
      db_rd && fc != `MBSRH_FC_EXCST |-> ptr <= (ctrl[2] ? 17'h0ffff : 17'h0270f);
  endproperty
  a_range: assert property (p_range) else $error("query beyond addressing range");
  property p_none;
    @(posedge clk iff ce) disable iff (!rst_n)
      state == S_END && rd_bin && fc != `MBSRH_FC_EXCST && !any |=> state == S_EXC ##1 acc[31:24] == 8'h01;
  endproperty
  a_none: assert property (p_none) else $error("empty bit read not refused");
  property p_wr_stop;
    @(posedge clk iff ce) disable iff (!rst_n)
      state == S_QWAIT && wr_op && !ok |=> state == S_EXC && !db_wr ##1 !db_wr;
  endproperty
  a_wr_stop: assert property (p_wr_stop) else $error("write went on past missing point");
  property p_foreign;
    @(posedge clk iff ce) disable iff (!rst_n)
      state == S_IDLE && req_valid && req_ready && !req_tcp && req_addr != slave_addr |=> state == S_IDLE;
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign address accepted");
  property p_inactive;
    @(posedge clk iff ce) disable iff (!rst_n)
      state == S_IDLE && req_valid && req_ready && (req_tcp ? !tcp_act : !ser_act) |=> state == S_IDLE;
  endproperty
  a_inactive: assert property (p_inactive) else $error("request served while inactive");
endmodule // mbsrh_top
`default_nettype wire

// ==== verification/mbsrh_db_model.sv ====
// point database model on the far side of the request handler
`timescale 1ns/1ps
`default_nettype none
module mbsrh_db_model (
  input wire logic clk,
  input wire logic db_rd,
  input wire logic [16:0] db_num,
  output mbsrh_pkg::mbsrh_kind_e db_kind,
  output logic db_wide,
  output logic [31:0] db_val,
  input wire logic pl_rd,
  output logic [7:0] pl_byte
);
  import mbsrh_pkg::*;
  initial begin
    db_val = 32'h0;
    pl_byte = 8'h0;
  end
  // data valid only the cycle after a strobe; inverted junk otherwise exposes stale use
  always @(posedge clk) begin
    db_wide <= 1'b0;
    db_kind <= KIND_NONE;
    db_val <= ~db_val;
    pl_byte <= pl_rd ? 8'h5a : ~pl_byte;
    if (db_rd) begin
      db_val <= 32'h1;
      if (db_num == 17'h0000b) db_kind <= KIND_PHYS_OUT;
      if (db_num == 17'h0000c) db_kind <= KIND_PHYS_IN;
      if (db_num == 17'h0000d) db_kind <= KIND_DERIVED;
      if (db_num == 17'h02710) db_kind <= KIND_PHYS_OUT;
      if (db_num[16:3] == 14'h186a) begin
        db_kind <= KIND_DERIVED;
        db_val <= {24'h0, 8'ha5 >> db_num[2:0]} & 32'h1;
      end
    end
  end
endmodule // mbsrh_db_model
`default_nettype wire

// ==== verification/tb_modbus_slave_request_handler.sv ====
// self-checking bench for the slave request handler
`timescale 1ns/1ps
`default_nettype none
module tb_modbus_slave_request_handler;
  import mbsrh_pkg::*;
  typedef struct {logic t; logic [7:0] a, f; logic [15:0] r, q, s; logic [7:0] l;
    int n; logic [39:0] e;} mbsrh_row_s;
  logic clk, rst_n, reg_wr, reg_rd, req_valid, req_ready, req_tcp, pl_rd, db_rd, db_ana;
  logic db_wide, db_wr, rsp_valid, rsp_last, rsp_tcp;
  logic [7:0] reg_addr, req_addr, req_fc, req_len, pl_idx, pl_byte, rsp_byte;
  logic [31:0] reg_wdata, reg_rdata, db_val, db_wval;
  logic [15:0] req_ref, req_qty, req_sub;
  logic [16:0] db_num;
  logic [2:0] req_sess, rsp_sess;
  mbsrh_kind_e db_kind;
  int miscompares = 0, samples_checked = 0, cyc = 0, n;
  logic [39:0] got, wlog;
  mbsrh_row_s rows[11] = '{
    '{0, 8'h01, 8'h01, 16'h000a, 16'h0004, 16'h0, 8'h0, 3, 40'h010105},
    '{1, 8'hff, 8'h02, 16'h000a, 16'h0004, 16'h0, 8'h0, 3, 40'h020106},
    '{0, 8'h01, 8'h01, 16'h0064, 16'h0002, 16'h0, 8'h0, 2, 40'h8101},
    '{1, 8'hff, 8'h07, 16'h0000, 16'h0000, 16'h0, 8'h0, 2, 40'h07a5},
    '{0, 8'h01, 8'h08, 16'h0000, 16'h1234, 16'h0, 8'h2, 5, 40'h0800001234},
    '{1, 8'hff, 8'h08, 16'h0000, 16'h1234, 16'h0, 8'h2, 2, 40'h8801},
    '{0, 8'h01, 8'h08, 16'h0000, 16'h1234, 16'h1, 8'h2, 2, 40'h8803},
    '{0, 8'h01, 8'h05, 16'h000a, 16'hff00, 16'h0, 8'h0, 5, 40'h05000aff00},
    '{0, 8'h01, 8'h05, 16'h0064, 16'hff00, 16'h0, 8'h0, 2, 40'h8501},
    '{1, 8'hff, 8'h11, 16'h0000, 16'h0000, 16'h0, 8'h0, 2, 40'h9101},
    '{0, 8'h01, 8'h01, 16'h270f, 16'h0001, 16'h0, 8'h0, 2, 40'h8101}};
  mbsrh_top u_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .req_valid(req_valid), .req_ready(req_ready), .req_tcp(req_tcp), .req_sess(req_sess),
    .req_addr(req_addr), .req_fc(req_fc), .req_ref(req_ref), .req_qty(req_qty),
    .req_sub(req_sub), .req_len(req_len), .pl_rd(pl_rd), .pl_idx(pl_idx), .pl_byte(pl_byte),
    .db_rd(db_rd), .db_ana(db_ana), .db_num(db_num), .db_kind(db_kind), .db_wide(db_wide),
    .db_val(db_val), .db_wr(db_wr), .db_wval(db_wval), .rsp_valid(rsp_valid),
    .rsp_byte(rsp_byte), .rsp_last(rsp_last), .rsp_ready(1'b1), .rsp_tcp(rsp_tcp),
    .rsp_sess(rsp_sess));
  mbsrh_db_model u_db (.clk(clk), .db_rd(db_rd), .db_num(db_num), .db_kind(db_kind),
    .db_wide(db_wide), .db_val(db_val), .pl_rd(pl_rd), .pl_byte(pl_byte));
  // last point write seen on the database side
  always @(posedge clk) begin
    if (db_wr === 1'b1) wlog <= {db_ana, db_num[6:0], db_wval};
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic rbus(input logic w, input logic [7:0] a, input logic [31:0] d);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge clk);
    got = {8'h0, reg_rdata};
  endtask
  // collects the response; n stays 0 when nothing comes within 60 cycles
  task automatic req(input mbsrh_row_s x);
    {req_valid, req_tcp, req_addr, req_fc, req_ref, req_qty, req_sub, req_len} <=
      {1'b1, x.t, x.a, x.f, x.r, x.q, x.s, x.l};
    do @(posedge clk); while (!req_ready);
    req_valid <= 1'b0;
    got = 40'h0;
    n = 0;
    for (int i = 0; i < 60; i++) begin
      @(posedge clk);
      if (rsp_valid === 1'b1) begin
        got = {got[31:0], rsp_byte};
        n++;
        if (rsp_last === 1'b1) break;
      end
    end
  endtask
  task automatic summarize();
    $display("miscompares=%0d samples_checked=%0d", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end
  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, req_valid, req_tcp, req_addr} = '0;
    {req_fc, req_ref, req_qty, req_sub, req_len, req_sess} = '0;
    rst_n = 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    req(rows[0]);
    chk(40'(n), 40'h0);
    rbus(1'b1, 8'h00, 32'h0000000b);
    rbus(1'b0, 8'h0c, 32'h0);
    chk(got, 40'h3);
    rbus(1'b0, 8'h20, 32'h0);
    chk(got, 40'h0);
    foreach (rows[i]) begin
      req(rows[i]);
      chk(40'(n), 40'(rows[i].n));
      chk(got, rows[i].e);
    end
    chk(wlog, 40'h0b00000001);
    rbus(1'b1, 8'h00, 32'h0000000f);
    req('{0, 8'h01, 8'h01, 16'h270f, 16'h0001, 16'h0, 8'h0, 0, 40'h0});
    chk(got, 40'h010101);
    req('{0, 8'h01, 8'h08, 16'h0, 16'h1234, 16'h0, 8'h3, 0, 40'h0});
    chk(40'(n), 40'h0);
    req('{0, 8'h02, 8'h07, 16'h0, 16'h0, 16'h0, 8'h0, 0, 40'h0});
    chk(40'(n), 40'h0);
    rbus(1'b0, 8'h10, 32'h0);
    chk(got, 40'hc);
    rbus(1'b0, 8'h14, 32'h0);
    chk(got, 40'h6);
    summarize();
  end
endmodule // tb_modbus_slave_request_handler
`default_nettype wire
